// file: design/lp3_bseq.sv
`timescale 1ns/100ps
module lp3_bseq (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic [1:0] start_col,
  output logic            beat_vld,
  output logic [2:0]      col,
  output logic            last
);
  logic [2:0] cnt_r;
  wire        at_end = (cnt_r == 3'h7);
  wire        pre_end = (cnt_r == 3'h6);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beat_vld <= 1'b0;
      col      <= 3'h0;
      last     <= 1'b0;
      cnt_r    <= 3'h0;
    end else if (start) begin
      beat_vld <= 1'b1;
      col      <= {start_col, 1'b0};
      last     <= 1'b0;
      cnt_r    <= 3'h0;
    end else if (beat_vld) begin
      beat_vld <= !at_end;
      col      <= col + 3'h1;
      last     <= pre_end;
      cnt_r    <= cnt_r + 3'h1;
    end
  end
endmodule

// file: design/lp3_ctl.sv
`timescale 1ns/100ps
module lp3_ctl #(
  parameter int TWR_NS = lp3_pkg::TWR_NS_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  lp3_link.ctrl            lk
);
  import lp3_pkg::*;

  // Recovery cycles the controller should program, rounded up
  localparam logic [4:0] NWR_CALC = 5'((TWR_NS * 1000 + TCK_PS - 1) / TCK_PS);

  lp3_cst_e   cs_r;
  logic [2:0] istat_r;
  logic [2:0] imask_r;
  logic [7:0] rdata_r;
  logic       vld_r;
  logic       wr_r;
  logic       bst_r;
  logic       ap_r;
  logic [7:0] ma_r;
  logic [7:0] op_r;
  logic [1:0] col_r;

  wire        setup   = psel && !penable;
  wire        acc_wr  = psel && penable && pwrite && pready;
  wire        cmd_wr  = acc_wr && (paddr == A_CMD);
  wire [7:0]  new_ma  = pwdata[CMD_MA_LO +: 8];
  wire [7:0]  new_op  = pwdata[CMD_OP_LO +: 8];
  wire        new_w   = pwdata[CMD_WR_BIT] && !pwdata[CMD_BST_BIT];
  wire        bad_ma  = new_w && ma_reserved(new_ma);
  wire        refuse  = cmd_wr && ((cs_r != CS_IDLE) || bad_ma);
  wire        launch  = cmd_wr && !refuse;
  wire [7:0]  feat_op = (new_op & ~FEAT_RSVD_MASK & 8'hF8) | {5'h00, BL8_CODE};
  wire [7:0]  out_op  = (new_w && (new_ma == MA_FEAT)) ? feat_op : new_op;
  wire        mapped  = (paddr == A_CMD) || (paddr == A_STAT) || (paddr == A_ISTAT) ||
                        (paddr == A_IMASK) || (paddr == A_NWR);
  wire [2:0]  ev_set  = {refuse, lk.done && lk.rd_vld, lk.done};
  wire [2:0]  ev_clr  = (acc_wr && (paddr == A_ISTAT)) ? pwdata[2:0] : 3'h0;
  // Set beats clear in the same cycle
  wire [2:0]  ist_nxt = (istat_r & ~ev_clr) | ev_set;
  wire [31:0] rd_mux  = (paddr == A_STAT)  ? {16'h0000, rdata_r, 7'h00, cs_r == CS_WAIT} :
                        (paddr == A_ISTAT) ? {29'h0, istat_r} :
                        (paddr == A_IMASK) ? {29'h0, imask_r} :
                        (paddr == A_NWR)   ? {27'h0, NWR_CALC} : 32'h0;

  assign lk.cmd_vld  = vld_r;
  assign lk.cmd_wr   = wr_r;
  assign lk.cmd_bst  = bst_r;
  assign lk.cmd_ap   = ap_r;
  assign lk.cmd_addr = ma_r;
  assign lk.cmd_op   = op_r;
  assign lk.cmd_col  = col_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= setup ? rd_mux : prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= 3'h0;
      imask_r <= 3'h0;
      irq     <= 1'b0;
    end else begin
      istat_r <= ist_nxt;
      imask_r <= (acc_wr && (paddr == A_IMASK)) ? pwdata[2:0] : imask_r;
      irq     <= |(istat_r & imask_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_r    <= CS_IDLE;
      vld_r   <= 1'b0;
      wr_r    <= 1'b0;
      bst_r   <= 1'b0;
      ap_r    <= 1'b0;
      ma_r    <= 8'h00;
      op_r    <= 8'h00;
      col_r   <= 2'h0;
      rdata_r <= 8'h00;
    end else begin
      vld_r <= launch;
      case (cs_r)
        CS_IDLE: cs_r <= launch ? CS_WAIT : CS_IDLE;
        CS_WAIT: cs_r <= lk.done ? CS_IDLE : CS_WAIT;
        default: cs_r <= CS_IDLE;
      endcase
      if (launch) begin
        wr_r  <= pwdata[CMD_WR_BIT];
        bst_r <= pwdata[CMD_BST_BIT];
        ap_r  <= pwdata[CMD_AP_BIT];
        ma_r  <= new_ma;
        op_r  <= out_op;
        col_r <= pwdata[CMD_COL_LO +: 2];
      end
      if (lk.done && lk.rd_vld) begin
        rdata_r <= lk.rd_data;
      end
    end
  end
endmodule

// file: design/lp3_dev.sv
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module lp3_dev #(
  parameter int   INIT_CYCLES = lp3_pkg::INIT_CYC_DEF,
  parameter logic ALT_WL      = 1'b1,
  parameter logic LOW_LAT     = 1'b1
) (
  input  wire logic pclk,
  input  wire logic presetn,
  lp3_link.dev      lk,
  input  wire logic [1:0] zq_sense,
  output logic [3:0] burst_len,
  output logic [4:0] wr_rec,
  output logic       ext_range,
  output logic       factory_trim,
  output logic       zq_cal,
  output logic       init_busy
);
  import lp3_pkg::*;

  localparam int IW = $clog2(INIT_CYCLES + 1);
  localparam logic [IW-1:0] INIT_LOAD = IW'(INIT_CYCLES);

  lp3_st_e       st_r;
  lp3_st_e       st_nxt;
  logic [1:0]    zq_s1_r;
  logic [1:0]    zq_s2_r;
  logic [1:0]    zq_r;
  logic [IW-1:0] init_cnt_r;
  logic [2:0]    wr_code_r;
  logic          ext_r;
  logic          ap_r;
  logic [4:0]    rec_cnt_r;
  logic          done_r;
  logic          rd_vld_r;
  logic [7:0]    rd_data_r;
  logic          dqs_r;
  logic          pre_r;
  logic          seq_vld;
  logic          seq_last;

  wire take    = lk.cmd_vld && (st_r == ST_IDLE);
  wire mrw     = take && lk.cmd_wr && !lk.cmd_bst;
  wire mrr     = take && !lk.cmd_wr && !lk.cmd_bst;
  wire bst     = take && lk.cmd_bst;
  wire wr_feat = mrw && (lk.cmd_addr == MA_FEAT);
  wire wr_ft2  = mrw && (lk.cmd_addr == MA_FEAT2);
  wire wr_rst  = mrw && (lk.cmd_addr == MA_RESET);
  // A suspected assembly fault locks calibration out until the next presetn reset
  wire zq_go   = mrw && (lk.cmd_addr == MA_ZQCAL) && (lk.cmd_op == OP_ZQ_INIT) && !factory_trim;
  wire zq_bad  = (zq_s2_r == ZQ_VDD) || (zq_s2_r == ZQ_GND);
  wire bl_ok   = (lk.cmd_op[FEAT_BL_LO +: 3] == BL8_CODE);
  wire init_nz = (init_cnt_r != '0);
  wire [4:0] rec_dec  = wr_rec_cycles(ext_r, wr_code_r);
  // Reserved codes decode to zero; still wait one cycle
  wire [4:0] rec_load = (rec_dec == 5'h00) ? 5'h01 : rec_dec;
  wire [7:0] info;

  assign info[INFO_INIT_BIT]        = init_busy;
  assign info[2:1]                  = 2'h0;
  assign info[INFO_ZQ_LO +: 2]      = zq_r;
  assign info[5]                    = 1'b0;
  assign info[INFO_ALTWL_BIT]       = ALT_WL;
  assign info[INFO_LOWLT_BIT]       = LOW_LAT;

  // Write-only and reserved reads return zero as their undefined data
  wire [7:0] rd_pick = (lk.cmd_addr == MA_INFO) ? info : 8'h00;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (mrr) begin
          st_nxt = ST_READ;
        end else if (bst) begin
          st_nxt = ST_WRITE;
        end
      end
      ST_READ: begin
        if (seq_last) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (seq_last) begin
          st_nxt = ap_r ? ST_REC : ST_IDLE;
        end
      end
      ST_REC: begin
        if (rec_cnt_r == 5'h01) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  lp3_bseq u_seq (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (mrr || bst),
    .start_col (mrr ? 2'h0 : lk.cmd_col),
    .beat_vld  (seq_vld),
    .col       (lk.beat_col),
    .last      (seq_last)
  );

  assign lk.beat_vld  = seq_vld;
  assign lk.done      = done_r;
  assign lk.rd_vld    = rd_vld_r;
  assign lk.rd_data   = rd_data_r;
  assign lk.dqs       = dqs_r;
  assign lk.pre_start = pre_r;

  // Pin levels pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zq_s1_r <= 2'h0;
      zq_s2_r <= 2'h0;
    end else begin
      zq_s1_r <= zq_sense;
      zq_s2_r <= zq_s1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt_r <= INIT_LOAD;
      init_busy  <= 1'b1;
    end else if (wr_rst) begin
      init_cnt_r <= INIT_LOAD;
      init_busy  <= 1'b1;
    end else begin
      init_cnt_r <= init_nz ? init_cnt_r - IW'(1) : init_cnt_r;
      init_busy  <= init_nz;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_code_r <= WR_DEF_CODE;
      ext_r     <= EXT_DEF;
    end else if (wr_rst) begin
      wr_code_r <= WR_DEF_CODE;
      ext_r     <= EXT_DEF;
    end else begin
      if (wr_feat && bl_ok) begin
        wr_code_r <= lk.cmd_op[FEAT_WR_LO +: 3];
      end
      if (wr_ft2) begin
        ext_r <= lk.cmd_op[FEAT2_EXT_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zq_r         <= ZQ_NONE;
      factory_trim <= 1'b0;
      zq_cal       <= 1'b0;
    end else begin
      zq_cal <= zq_go;
      if (zq_go) begin
        zq_r         <= zq_s2_r;
        factory_trim <= zq_bad;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= ST_IDLE;
      ap_r      <= 1'b0;
      rec_cnt_r <= 5'h00;
      done_r    <= 1'b0;
      rd_vld_r  <= 1'b0;
      rd_data_r <= 8'h00;
      dqs_r     <= 1'b0;
      pre_r     <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      done_r   <= mrw || (seq_last && (st_r == ST_READ)) || (seq_last && (st_r == ST_WRITE) && !ap_r) ||
                  ((st_r == ST_REC) && (rec_cnt_r == 5'h01));
      rd_vld_r <= seq_last && (st_r == ST_READ);
      pre_r    <= (st_r == ST_REC) && (rec_cnt_r == 5'h01);
      dqs_r    <= seq_vld && (st_r == ST_READ) ? !dqs_r : 1'b0;
      if (take) begin
        ap_r <= lk.cmd_ap;
      end
      if (mrr) begin
        rd_data_r <= rd_pick;
      end
      if ((st_r == ST_WRITE) && seq_last) begin
        rec_cnt_r <= rec_load;
      end else if (st_r == ST_REC) begin
        rec_cnt_r <= rec_cnt_r - 5'h01;
      end
    end
  end

  // Writes to the info register and other read-only numbers fall through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_len <= BL8_LEN;
      wr_rec    <= 5'h0A;
      ext_range <= EXT_DEF;
    end else begin
      burst_len <= BL8_LEN;
      wr_rec    <= rec_dec;
      ext_range <= ext_r;
    end
  end
endmodule

// file: include/lp3_link.sv
`timescale 1ns/100ps
interface lp3_link;
  logic       cmd_vld;
  logic       cmd_wr;
  logic       cmd_bst;
  logic       cmd_ap;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_op;
  logic [1:0] cmd_col;
  logic       done;
  logic       rd_vld;
  logic [7:0] rd_data;
  logic       dqs;
  logic       beat_vld;
  logic [2:0] beat_col;
  logic       pre_start;

  modport ctrl (
    output cmd_vld, cmd_wr, cmd_bst, cmd_ap, cmd_addr, cmd_op, cmd_col,
    input  done, rd_vld, rd_data, dqs, beat_vld, beat_col, pre_start
  );
  modport dev (
    input  cmd_vld, cmd_wr, cmd_bst, cmd_ap, cmd_addr, cmd_op, cmd_col,
    output done, rd_vld, rd_data, dqs, beat_vld, beat_col, pre_start
  );
endinterface

// file: include/lp3_pkg.sv
package lp3_pkg;
  localparam logic [7:0]  MA_INFO        = 8'h00;
  localparam logic [7:0]  MA_FEAT        = 8'h01;
  localparam logic [7:0]  MA_FEAT2       = 8'h02;
  localparam logic [7:0]  MA_ZQCAL       = 8'h0A;
  localparam logic [7:0]  MA_RESET       = 8'h3F;
  localparam logic [7:0]  OP_ZQ_INIT     = 8'hFF;
  localparam int          INFO_INIT_BIT  = 0;
  localparam int          INFO_ZQ_LO     = 3;
  localparam int          INFO_ALTWL_BIT = 6;
  localparam int          INFO_LOWLT_BIT = 7;
  localparam int          FEAT_BL_LO     = 0;
  localparam int          FEAT_WR_LO     = 5;
  localparam int          FEAT2_EXT_BIT  = 4;
  localparam logic [7:0]  FEAT_RSVD_MASK = 8'h18;
  localparam logic [2:0]  BL8_CODE       = 3'h3;
  localparam logic [3:0]  BL8_LEN        = 4'h8;
  localparam logic [2:0]  WR_DEF_CODE    = 3'h0;
  localparam logic        EXT_DEF        = 1'b1;
  localparam logic [1:0]  ZQ_NONE        = 2'h0;
  localparam logic [1:0]  ZQ_VDD         = 2'h1;
  localparam logic [1:0]  ZQ_GND         = 2'h2;
  localparam logic [1:0]  ZQ_PASS        = 2'h3;
  localparam int          INIT_CYC_DEF   = 16;
  localparam logic [11:0] A_CMD          = 12'h000;
  localparam logic [11:0] A_STAT         = 12'h004;
  localparam logic [11:0] A_ISTAT        = 12'h008;
  localparam logic [11:0] A_IMASK        = 12'h00C;
  localparam logic [11:0] A_NWR          = 12'h010;
  localparam int          CMD_OP_LO      = 0;
  localparam int          CMD_MA_LO      = 8;
  localparam int          CMD_WR_BIT     = 16;
  localparam int          CMD_BST_BIT    = 17;
  localparam int          CMD_AP_BIT     = 18;
  localparam int          CMD_COL_LO     = 19;
  localparam int          IRQ_DONE       = 0;
  localparam int          IRQ_RDATA      = 1;
  localparam int          IRQ_REFUSE     = 2;
  localparam int          CLK_MHZ        = 100;
  localparam int          TCK_PS         = 1000000 / CLK_MHZ;
  localparam int          TWR_NS_DEF     = 15;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10,
    ST_REC   = 2'b11
  } lp3_st_e;

  typedef enum logic {
    CS_IDLE = 1'b0,
    CS_WAIT = 1'b1
  } lp3_cst_e;

  function automatic logic [4:0] wr_rec_cycles(input logic ext, input logic [2:0] code);
    case ({ext, code})
      4'h1:    wr_rec_cycles = 5'h03;
      4'h4:    wr_rec_cycles = 5'h06;
      4'h6:    wr_rec_cycles = 5'h08;
      4'h7:    wr_rec_cycles = 5'h09;
      4'h8:    wr_rec_cycles = 5'h0A;
      4'h9:    wr_rec_cycles = 5'h0B;
      4'hA:    wr_rec_cycles = 5'h0C;
      4'hC:    wr_rec_cycles = 5'h0E;
      4'hE:    wr_rec_cycles = 5'h10;
      default: wr_rec_cycles = 5'h00;
    endcase
  endfunction

  function automatic logic ma_reserved(input logic [7:0] ma);
    ma_reserved = (ma >= 8'h0C && ma <= 8'h0F) || (ma >= 8'h12 && ma <= 8'h1F) ||
                  (ma >= 8'h21 && ma <= 8'h27) || (ma >= 8'h2B && ma <= 8'h2F) ||
                  (ma >= 8'h31 && ma <= 8'h3E) || (ma >= 8'h40);
  endfunction
endpackage

// file: verification/lp3_asserts.sv
`timescale 1ns/100ps
module lp3_asserts
  import lp3_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       cmd_vld,
  input wire logic       cmd_wr,
  input wire logic       cmd_bst,
  input wire logic       cmd_ap,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_op,
  input wire logic [1:0] cmd_col,
  input wire logic       done,
  input wire logic       rd_vld,
  input wire logic [7:0] rd_data,
  input wire logic       dqs,
  input wire logic       beat_vld,
  input wire logic [2:0] beat_col,
  input wire logic       pre_start
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] ma_r;
  wire        rd_go  = cmd_vld && !cmd_wr && !cmd_bst;
  wire        bst_go = cmd_vld && !cmd_wr;
  // Remembers which register a read answer belongs to
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ma_r <= 8'h00;
    else if (cmd_vld) ma_r <= cmd_addr;
  end
  a_burst_eight: assert property (bst_go |=> beat_vld [*8] ##1 !beat_vld)
    else $error("burst is not eight beats");
  a_read_done: assert property (rd_go |-> ##9 (done && rd_vld))
    else $error("read answer late or missing");
  a_dqs_toggle: assert property (rd_go |-> ##2 $changed(dqs) [*8])
    else $error("strobe did not toggle on read");
  a_mrw_done: assert property (cmd_vld && cmd_wr && !cmd_bst |=> done && !beat_vld)
    else $error("mode write not finished in one cycle");
  a_first_col: assert property (bst_go |=> beat_col == {$past(cmd_col), 1'b0})
    else $error("burst start column wrong");
  a_col_wrap: assert property (beat_vld && $past(beat_vld) |-> beat_col == $past(beat_col) + 3'h1)
    else $error("burst column order wrong");
  a_col_even: assert property (beat_vld && !$past(beat_vld) |-> !beat_col[0])
    else $error("lowest column bit set");
  a_info_zero: assert property (rd_vld && ma_r == MA_INFO |-> (rd_data & 8'h26) == 8'h00)
    else $error("reserved info bits not zero");
  a_feat_op: assert property (cmd_vld && cmd_wr && cmd_addr == MA_FEAT |-> cmd_op[4:0] == {2'h0, BL8_CODE})
    else $error("feature operand not legal");
  a_no_rsvd: assert property (cmd_vld && cmd_wr |-> cmd_addr < 8'h40 && !(cmd_addr inside {[8'h0C:8'h0F]}))
    else $error("write to reserved register number");
  a_pre_done: assert property (pre_start |-> done)
    else $error("precharge start without done");
  c_read: cover property (rd_go ##9 rd_vld);
  c_pre: cover property (pre_start);
  c_reset: cover property (cmd_vld && cmd_wr && cmd_addr == MA_RESET);
endmodule

// file: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import lp3_pkg::*;
  localparam int INIT_N = 40;
  localparam int TWR    = 15;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  zq_sense;
  logic [3:0]  burst_len;
  logic [4:0]  wr_rec;
  logic        ext_range, factory_trim, zq_cal, init_busy;
  logic [2:0]  cols[$];
  int          failures, compares, cyc, ncal, last_beat, pre_at;
  lp3_link i_lp3_link();
  lp3_ctl #(.TWR_NS(TWR)) i_lp3_ctl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .lk(i_lp3_link));
  lp3_dev #(.INIT_CYCLES(INIT_N)) i_lp3_dev (.pclk, .presetn, .lk(i_lp3_link), .zq_sense, .burst_len,
    .wr_rec, .ext_range, .factory_trim, .zq_cal, .init_busy);
  lp3_asserts i_lp3_asserts (.pclk, .presetn, .cmd_vld(i_lp3_link.cmd_vld), .cmd_wr(i_lp3_link.cmd_wr),
    .cmd_bst(i_lp3_link.cmd_bst), .cmd_ap(i_lp3_link.cmd_ap), .cmd_addr(i_lp3_link.cmd_addr),
    .cmd_op(i_lp3_link.cmd_op), .cmd_col(i_lp3_link.cmd_col), .done(i_lp3_link.done),
    .rd_vld(i_lp3_link.rd_vld), .rd_data(i_lp3_link.rd_data), .dqs(i_lp3_link.dqs),
    .beat_vld(i_lp3_link.beat_vld), .beat_col(i_lp3_link.beat_col), .pre_start(i_lp3_link.pre_start));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task give_verdict;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Beat monitor and hang guard
  always @(posedge pclk) begin
    cyc++;
    if (i_lp3_link.beat_vld === 1'b1) begin
      cols.push_back(i_lp3_link.beat_col);
      last_beat = cyc;
    end
    if (i_lp3_link.pre_start === 1'b1) pre_at = cyc;
    if (zq_cal === 1'b1) ncal++;
    if (cyc > 30000) begin
      failures++;
      give_verdict();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count is assumed; the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Kind is {ap, burst, write}; waits for the controller to go idle
  task mcmd(input logic [7:0] ma, input logic [7:0] op, input logic [2:0] kind, input logic [1:0] col);
    apb(1'b1, A_CMD, {11'h000, col, kind, ma, op});
    do begin
      apb(1'b0, A_STAT, 32'h0);
    end while (rd[0] !== 1'b0);
  endtask

  task rinfo;
    mcmd(MA_INFO, 8'h00, 3'h0, 2'h0);
    apb(1'b0, A_STAT, 32'h0);
  endtask

  task zq_run(input logic [1:0] s);
    zq_sense <= s;
    repeat (4) @(posedge pclk);
    mcmd(MA_ZQCAL, OP_ZQ_INIT, 3'h1, 2'h0);
    rinfo();
  endtask

  function automatic logic [4:0] exp_wr(input logic e, input logic [2:0] c);
    case ({e, c})
      4'h1: return 5'h03;
      4'h4: return 5'h06;
      4'h6: return 5'h08;
      4'h7: return 5'h09;
      4'h8: return 5'h0A;
      4'h9: return 5'h0B;
      4'hA: return 5'h0C;
      4'hC: return 5'h0E;
      4'hE: return 5'h10;
      default: return 5'h00;
    endcase
  endfunction

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    zq_sense = ZQ_NONE;
    void'($urandom(85));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(burst_len, BL8_LEN);
    chk(wr_rec, 5'h0A);
    chk(ext_range, 1'b1);
    chk(init_busy, 1'b1);
    apb(1'b0, A_NWR, 32'h0);
    chk(rd, 32'((TWR * 1000 + 9999) / 10000));
    apb(1'b0, A_IMASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0FC, 32'hFFFF_FFFF);
    chk({er, rd}, {1'b1, 32'h0});
    // Init may still run: all info bits but the init flag are compared here
    rinfo();
    chk(rd[15:9], 7'h60);
    // Self-test field only moves on init calibration; a fault freezes it
    while (init_busy !== 1'b0) @(posedge pclk);
    zq_run(ZQ_PASS);
    chk({factory_trim, rd[12:8]}, {1'b0, ZQ_PASS, 3'h0});
    zq_sense <= ZQ_GND;
    repeat (4) @(posedge pclk);
    mcmd(MA_FEAT, 8'h03, 3'h1, 2'h0);
    rinfo();
    chk(rd[12:11], ZQ_PASS);
    zq_run(ZQ_GND);
    chk({factory_trim, rd[12:11]}, {1'b1, ZQ_GND});
    zq_run(ZQ_VDD);
    chk(ncal, 2);
    chk(rd[12:11], ZQ_GND);
    for (int e = 0; e < 2; e++) begin
      for (int c = 0; c < 8; c++) begin
        mcmd(MA_FEAT2, {3'h0, e[0], 4'h0}, 3'h1, 2'h0);
        mcmd(MA_FEAT, {c[2:0], 5'($urandom)}, 3'h1, 2'h0);
        chk({ext_range, wr_rec}, {e[0], exp_wr(e[0], c[2:0])});
      end
    end
    mcmd(MA_FEAT, 8'hC3, 3'h1, 2'h0);
    mcmd(MA_INFO, 8'($urandom), 3'h1, 2'h0);
    chk(wr_rec, exp_wr(1'b1, 3'h6));
    for (int c = 0; c < 4; c++) begin
      cols.delete();
      mcmd(8'h00, 8'h00, 3'h6, c[1:0]);
      chk(cols.size(), 8);
      foreach (cols[k]) chk(cols[k], 3'({c[1:0], 1'b0} + k));
      chk(pre_at - last_beat, exp_wr(1'b1, 3'h6) + 1);
    end
    // Burst without auto-precharge: no internal precharge start
    pre_at = 0;
    cols.delete();
    mcmd(8'h00, 8'h00, 3'h2, 2'h3);
    chk(cols.size(), 8);
    chk(cols[0], 3'h6);
    chk(pre_at, 0);
    mcmd(MA_FEAT, 8'h00, 3'h0, 2'h0);
    // Refused write, masked then unmasked interrupt
    apb(1'b1, A_ISTAT, 32'h7);
    mcmd(8'h40 | 8'($urandom), 8'h00, 3'h1, 2'h0);
    apb(1'b0, A_ISTAT, 32'h0);
    chk(rd[2:0], 3'h4);
    chk(irq, 1'b0);
    apb(1'b1, A_IMASK, 32'h4);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, A_ISTAT, 32'h4);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    mcmd(MA_RESET, 8'($urandom), 3'h1, 2'h0);
    chk({init_busy, ext_range, wr_rec}, {2'h3, 5'h0A});
    rinfo();
    chk(rd[8], 1'b1);
    for (int n = 0; n < 100 && init_busy !== 1'b0; n++) @(posedge pclk);
    rinfo();
    chk(rd[8], 1'b0);
    // Second reset clears the fault so the last code can be seen
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    zq_run(ZQ_VDD);
    chk({factory_trim, rd[12:11]}, {1'b1, ZQ_VDD});
    give_verdict();
  end
endmodule
